// ---- src/tps_pkg.sv ----
/*
 * Shared constants, types and helpers for the timer prescaler and clock
 * select block. Assumes a single 50 MHz system clock and an Avalon-MM
 * host that reaches the registers through 32-bit aligned words.
 */

package tps_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] TPS_GTC_IDX    = 8'h23;
  localparam logic [7:0] TPS_CSEL_IDX   = 8'h24;
  localparam logic [7:0] TPS_STAT_IDX   = 8'h25;
  localparam logic [9:0] TPS_GTC_ADDR   = {TPS_GTC_IDX, 2'b00};
  localparam logic [9:0] TPS_CSEL_ADDR  = {TPS_CSEL_IDX, 2'b00};
  localparam logic [9:0] TPS_STAT_ADDR  = {TPS_STAT_IDX, 2'b00};

  localparam int unsigned TPS_TSM_BIT   = 7;
  localparam int unsigned TPS_PSR_BIT   = 0;
  localparam int unsigned TPS_CS0_LSB   = 0;
  localparam int unsigned TPS_CS1_LSB   = 4;
  localparam int unsigned TPS_STAT_PIN  = 16;
  localparam logic [7:0]  TPS_GTC_RST   = 8'h00;
  localparam logic [7:0]  TPS_CSEL_RST  = 8'h00;

  // ==========================================================================
  // Clock select codes and prescaler
  // ==========================================================================
  localparam logic [2:0] TPS_CS_NONE     = 3'h0;
  localparam logic [2:0] TPS_CS_DIRECT   = 3'h1;
  localparam logic [2:0] TPS_CS_DIV8     = 3'h2;
  localparam logic [2:0] TPS_CS_DIV64    = 3'h3;
  localparam logic [2:0] TPS_CS_DIV256   = 3'h4;
  localparam logic [2:0] TPS_CS_DIV1024  = 3'h5;
  localparam logic [2:0] TPS_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TPS_CS_EXT_RISE = 3'h7;

  localparam int unsigned TPS_PRESC_W  = 10;
  localparam int unsigned TPS_LOG2_8   = 3;
  localparam int unsigned TPS_LOG2_64  = 6;
  localparam int unsigned TPS_LOG2_256 = 8;
  localparam logic [9:0]  TPS_PRESC_RST = 10'h000;

  typedef enum logic [1:0] {
    TPS_BUS_IDLE = 2'b00,
    TPS_BUS_ACK  = 2'b01
  } tps_bus_t;

  // True when the low n bits of the prescaler count are all ones.
  function automatic logic tps_low_ones(input logic [9:0] cnt,
                                        input int unsigned n);
    logic [9:0] mask;
    mask = 10'((1 << n) - 1);
    return (cnt & mask) == mask;
  endfunction

endpackage

// ---- src/tps_tap_if.sv ----
/*
 * Carries the four prescaler tap pulses from the shared divider to each
 * clock selector. Assumes one producer and any number of readers.
 */
`timescale 1ns/1ps

interface tps_tap_if;
  logic [3:0] tap;
  modport src (output tap);
  modport snk (input  tap);
endinterface // tps_tap_if

// ---- src/tps_edge_sync.sv ----
/*
 * Count pin synchroniser and edge detector for one timer. Assumes the pin
 * is asynchronous to i_clk and that i_rst_n is already synchronised.
 */
`timescale 1ns/1ps

module tps_edge_sync
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Pin and edge events
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ==========================================================================
  // Two-stage sampling then one history flop
  // ==========================================================================
  // The first stage stands in for the transparent-high latch; a flop keeps
  // the design free of latches with the same worst-case delay.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_rise  = sync_r & ~prev_r;
  assign o_fall  = ~sync_r & prev_r;

  chk_edge_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(sync_r) |-> o_rise && !o_fall)
    else $error("rising edge not reported");
  chk_edge_single: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_rise |=> !o_rise)
    else $error("rising edge reported twice");

endmodule // tps_edge_sync

// ---- src/tps_clk_select.sv ----
/*
 * Per-timer clock source selector. Assumes tap pulses are one cycle wide
 * and edge events come from the pin synchroniser on the same clock.
 */
`timescale 1ns/1ps

module tps_clk_select
  import tps_pkg::*;
(
  // Clock and reset, used only by the checks
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Selection and sources
  input  wire logic [2:0] i_clock_source_sel,
  tps_tap_if.snk          taps,
  input  wire logic       i_rise,
  input  wire logic       i_fall,
  // Selected tick
  output logic            o_tick
);

  wire sel_direct = (i_clock_source_sel == TPS_CS_DIRECT);
  wire sel_tap    = (i_clock_source_sel >= TPS_CS_DIV8) &&
                    (i_clock_source_sel <= TPS_CS_DIV1024);
  wire [1:0] tap_idx = 2'(i_clock_source_sel - TPS_CS_DIV8);
  // External events bypass the divider entirely.
  wire ext_tick = (i_clock_source_sel == TPS_CS_EXT_RISE && i_rise) ||
                  (i_clock_source_sel == TPS_CS_EXT_FALL && i_fall);

  assign o_tick = sel_direct || (sel_tap && taps.tap[tap_idx]) ||
                  ext_tick;

  chk_sel_none: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_clock_source_sel == TPS_CS_NONE |-> !o_tick)
    else $error("tick with no source selected");
  chk_sel_div64: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_clock_source_sel == TPS_CS_DIV64 |-> o_tick == taps.tap[1])
    else $error("select three not mapped to divide by 64");

endmodule // tps_clk_select

// ---- src/tps_top.sv ----
/*
 * Shared timer prescaler with two clock selectors, a count pin path for
 * each timer and an Avalon-MM register slave. Assumes a 50 MHz clock,
 * asynchronous count pins and a master that honours waitrequest.
 */
`timescale 1ns/1ps

module tps_top
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Count pins, timer ticks and prescaler reset
  input  wire logic [1:0]  i_ext_count_pin,
  output logic      [1:0]  o_timer_tick,
  output logic             o_sync_prescaler_reset
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  tps_bus_t    bus_r;
  tps_bus_t    bus_nxt;
  logic        sync_hold_mode_r;
  logic        sync_prescaler_reset_r;
  logic        sync_prescaler_reset_nxt;
  logic [2:0]  cs0_r;
  logic [2:0]  cs1_r;
  logic [9:0]  presc_r;
  logic [9:0]  presc_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  tick_w;
  logic [1:0]  level_w;
  logic [1:0]  rise_w;
  logic [1:0]  fall_w;

  tps_tap_if tap_bus ();

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // Every access costs one wait cycle: waitrequest drops for exactly one
  // cycle, and that is the edge where writes land and read data is valid.
  wire bus_req    = i_avs_read || i_avs_write;
  wire bus_accept = (bus_r == TPS_BUS_ACK);
  wire hit_gtc    = (i_avs_address == TPS_GTC_ADDR);
  wire hit_csel   = (i_avs_address == TPS_CSEL_ADDR);
  wire hit_stat   = (i_avs_address == TPS_STAT_ADDR);
  wire wr_gtc     = bus_accept && i_avs_write && hit_gtc;
  wire wr_csel    = bus_accept && i_avs_write && hit_csel;

  wire [7:0] gtc_view = {sync_hold_mode_r, 6'h00,
                         sync_prescaler_reset_r};
  wire [31:0] csel_view = 32'({1'b0, cs1_r, 1'b0, cs0_r});
  // Status packs the prescaler count in the low ten bits and the two
  // synchronised pin levels at bits 17:16; everything between reads zero.
  wire [31:0] stat_view = 32'({level_w, 6'h00, presc_r});

  assign rdata_nxt = hit_gtc  ? {24'h000000, gtc_view} :
                     hit_csel ? csel_view :
                     hit_stat ? stat_view : 32'h00000000;

  assign bus_nxt = (bus_r == TPS_BUS_IDLE && bus_req) ? TPS_BUS_ACK
                                                      : TPS_BUS_IDLE;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_r             <= TPS_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      bus_r             <= bus_nxt;
      o_avs_waitrequest <= (bus_nxt != TPS_BUS_ACK);
      if (bus_nxt == TPS_BUS_ACK) begin
        o_avs_readdata <= i_avs_read ? rdata_nxt : 32'h00000000;
      end
    end
  end

  // ==========================================================================
  // General timer control
  // ==========================================================================
  // A write loads the reset bit as written; otherwise the bit drops unless
  // sync-hold keeps it. Writing sync-hold low with the reset bit low
  // therefore frees both timers on the same edge.
  assign sync_prescaler_reset_nxt =
      wr_gtc ? i_avs_writedata[TPS_PSR_BIT] :
      (sync_hold_mode_r && sync_prescaler_reset_r);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_hold_mode_r       <= TPS_GTC_RST[TPS_TSM_BIT];
      sync_prescaler_reset_r <= TPS_GTC_RST[TPS_PSR_BIT];
    end else begin
      if (wr_gtc) begin
        sync_hold_mode_r <= i_avs_writedata[TPS_TSM_BIT];
      end
      sync_prescaler_reset_r <= sync_prescaler_reset_nxt;
    end
  end

  // Each timer keeps its own select field; neither touches the divider.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs0_r <= TPS_CSEL_RST[TPS_CS0_LSB +: 3];
      cs1_r <= TPS_CSEL_RST[TPS_CS1_LSB +: 3];
    end else if (wr_csel) begin
      cs0_r <= i_avs_writedata[TPS_CS0_LSB +: 3];
      cs1_r <= i_avs_writedata[TPS_CS1_LSB +: 3];
    end
  end

  // ==========================================================================
  // Shared prescaler
  // ==========================================================================
  // Free running; only the reset bit restarts it, so a timer enabled
  // mid-period sees its first tap after 1 to N+1 cycles.
  assign presc_nxt = sync_prescaler_reset_r ? TPS_PRESC_RST
                                            : presc_r + 10'h001;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= TPS_PRESC_RST;
    end else begin
      presc_r <= presc_nxt;
    end
  end

  // Taps are silent while the reset bit is held, which halts prescaled
  // timers during a synchronised setup.
  assign tap_bus.tap[0] = !sync_prescaler_reset_r &&
                          tps_low_ones(presc_r, TPS_LOG2_8);
  assign tap_bus.tap[1] = !sync_prescaler_reset_r &&
                          tps_low_ones(presc_r, TPS_LOG2_64);
  assign tap_bus.tap[2] = !sync_prescaler_reset_r &&
                          tps_low_ones(presc_r, TPS_LOG2_256);
  assign tap_bus.tap[3] = !sync_prescaler_reset_r &&
                          tps_low_ones(presc_r, TPS_PRESC_W);

  // ==========================================================================
  // Per-timer clock paths
  // ==========================================================================
  tps_edge_sync u_edge0 (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_pin   (i_ext_count_pin[0]),
    .o_level (level_w[0]),
    .o_rise  (rise_w[0]),
    .o_fall  (fall_w[0])
  );

  tps_edge_sync u_edge1 (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_pin   (i_ext_count_pin[1]),
    .o_level (level_w[1]),
    .o_rise  (rise_w[1]),
    .o_fall  (fall_w[1])
  );

  tps_clk_select u_sel0 (
    .i_clk              (i_clk),
    .i_rst_n            (rst_n),
    .i_clock_source_sel (cs0_r),
    .taps               (tap_bus.snk),
    .i_rise             (rise_w[0]),
    .i_fall             (fall_w[0]),
    .o_tick             (tick_w[0])
  );

  tps_clk_select u_sel1 (
    .i_clk              (i_clk),
    .i_rst_n            (rst_n),
    .i_clock_source_sel (cs1_r),
    .taps               (tap_bus.snk),
    .i_rise             (rise_w[1]),
    .i_fall             (fall_w[1]),
    .o_tick             (tick_w[1])
  );

  // The output flop adds the last cycle of the pin-to-tick delay.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_timer_tick           <= 2'b00;
      o_sync_prescaler_reset <= 1'b0;
    end else begin
      o_timer_tick           <= tick_w;
      o_sync_prescaler_reset <= sync_prescaler_reset_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_direct_every_cycle: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    cs0_r == TPS_CS_DIRECT |=> o_timer_tick[0])
    else $error("direct select missed a cycle");

  chk_tap8_period: assert property (@(posedge i_clk) disable iff (!rst_n)
    tap_bus.tap[0] ##1 (!sync_prescaler_reset_r)[*7]
      |=> tap_bus.tap[0] || sync_prescaler_reset_r)
    else $error("divide by 8 tap period wrong");

  // The divider holds its reset value for one more edge as reset lifts, so
  // the sampled reset copy gates the antecedent.
  chk_free_run: assert property (@(posedge i_clk) disable iff (!rst_n)
    rst_n && !sync_prescaler_reset_r
      |=> presc_r == $past(presc_r) + 10'h001)
    else $error("prescaler did not advance");

  chk_reset_restart: assert property (@(posedge i_clk) disable iff (!rst_n)
    sync_prescaler_reset_r |=> presc_r == TPS_PRESC_RST)
    else $error("prescaler reset did not restart divider");

  chk_reset_self_clear: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    sync_prescaler_reset_r && !sync_hold_mode_r && !wr_gtc
      |=> !sync_prescaler_reset_r)
    else $error("prescaler reset bit did not self clear");

  chk_hold_keeps_reset: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    sync_prescaler_reset_r && sync_hold_mode_r && !wr_gtc
      |=> sync_prescaler_reset_r)
    else $error("sync hold lost the prescaler reset");

  chk_hold_release: assert property (@(posedge i_clk) disable iff (!rst_n)
    wr_gtc && !i_avs_writedata[TPS_TSM_BIT] && !i_avs_writedata[TPS_PSR_BIT]
      |=> !sync_prescaler_reset_r && !sync_hold_mode_r)
    else $error("clearing sync hold left reset asserted");

  chk_resv_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
    bus_accept && i_avs_read && hit_gtc
      |-> o_avs_readdata[6:1] == 6'h00)
    else $error("reserved control bits read nonzero");

  chk_ext_delay: assert property (@(posedge i_clk) disable iff (!rst_n)
    cs0_r == TPS_CS_EXT_RISE && $stable(cs0_r) && rise_w[0]
      |=> o_timer_tick[0])
    else $error("external edge tick late");

  // ==========================================================================
  // Bus, reset output and tap structure checks
  // ==========================================================================
  // The reset output is a second flop loaded from the same next value, so
  // it must never drift from the register bit that software reads.
  chk_psr_out_align: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_sync_prescaler_reset == sync_prescaler_reset_r)
    else $error("prescaler reset output out of step");

  chk_taps_silent: assert property (@(posedge i_clk) disable iff (!rst_n)
    sync_prescaler_reset_r |-> tap_bus.tap == 4'h0)
    else $error("tap pulsed while prescaler held");

  // A slower tap can only fire on a cycle where every faster tap fires.
  chk_tap_nesting: assert property (@(posedge i_clk) disable iff (!rst_n)
    tap_bus.tap[3] |-> tap_bus.tap[2] && tap_bus.tap[1] && tap_bus.tap[0])
    else $error("divide by 1024 tap out of phase");

  chk_wait_single: assert property (@(posedge i_clk) disable iff (!rst_n)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");


  cov_direct: cover property (@(posedge i_clk) disable iff (!rst_n)
    cs0_r == TPS_CS_DIRECT && o_timer_tick[0]);
  cov_hold: cover property (@(posedge i_clk) disable iff (!rst_n)
    sync_hold_mode_r && sync_prescaler_reset_r ##1 !sync_prescaler_reset_r);
  cov_ext_fall: cover property (@(posedge i_clk) disable iff (!rst_n)
    cs1_r == TPS_CS_EXT_FALL && o_timer_tick[1]);
  cov_ext_rise: cover property (@(posedge i_clk) disable iff (!rst_n)
    cs0_r == TPS_CS_EXT_RISE && o_timer_tick[0]);
  cov_tap1024: cover property (@(posedge i_clk) disable iff (!rst_n)
    tap_bus.tap[3]);

endmodule // tps_top

// ---- verification/tps_pin_src.sv ----
/*
 * Count source model for the timer prescaler bench: both count pins carry
 * one square wave. Assumes the bench clock and a go pulse to start.
 */
`timescale 1ns/1ps

module tps_pin_src (
  // Clock and control
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_half,
  input  wire logic [7:0] i_pulses,
  // Count pins
  output logic      [1:0] o_pin
);
  logic [8:0] left_r;
  logic [7:0] cnt_r;

  initial begin
    o_pin  = 2'h0;
    left_r = 9'h000;
    cnt_r  = 8'h00;
  end

  // ==========================================================================
  // Wave generation
  // ==========================================================================
  // Each level is held i_half cycles and the pin rests low between bursts,
  // so a select change never meets a moving pin.
  always @(posedge i_clk) begin
    if (i_go) begin
      left_r <= {i_pulses, 1'b0};
      cnt_r  <= 8'h00;
    end else if (left_r != 9'h000) begin
      if (cnt_r == i_half - 8'h01) begin
        o_pin  <= ~o_pin;
        left_r <= left_r - 9'h001;
        cnt_r  <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // tps_pin_src

// ---- verification/tps_top_tb_top.sv ----
/*
 * Self-checking bench for the timer prescaler block. Assumes the register
 * map of tps_pkg and one wait state on every bus access.
 */
`timescale 1ns/1ps

module tps_top_tb_top;
  import tps_pkg::*;
  logic        clk, rst_n, rd, wr, go, waitreq, psr;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata, q, s0;
  logic [1:0]  pin, tick, pin_q;
  logic [7:0]  half, pulses;
  int          cyc, err_total, checks, last, c0, d;
  int          tick_cnt[2], tick_cyc[2], tick_prev[2], rise_cyc, fall_cyc;
  int          divs[4] = '{8, 64, 256, 1024};

  tps_top tps_top_inst (.i_clk(clk), .i_reset_n(rst_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_ext_count_pin(pin),
    .o_timer_tick(tick), .o_sync_prescaler_reset(psr));
  tps_pin_src tps_pin_src_inst (.i_clk(clk), .i_go(go), .i_half(half),
    .i_pulses(pulses), .o_pin(pin));

  // ==========================================================================
  // Clock, cycle count and monitors
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_total++;
      end_of_test();
    end
  end

  // Sampling on the falling edge keeps the monitor clear of drive updates.
  always @(negedge clk) begin
    for (int t = 0; t < 2; t++) begin
      if (tick[t] === 1'b1) begin
        tick_prev[t] = tick_cyc[t];
        tick_cyc[t]  = cyc;
        tick_cnt[t]++;
      end
    end
    if (pin[0] === 1'b1 && pin_q[0] === 1'b0) rise_cyc = cyc;
    if (pin[1] === 1'b0 && pin_q[1] === 1'b1) fall_cyc = cyc;
    pin_q = pin;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= w;
    rd    <= ~w;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata;
    last = cyc;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic wait_ticks(input int t, input int n);
    int s, k;
    k = 0;
    // Let a tick launched under the previous select be counted first, and
    // poll on the rising edge so the falling-edge monitor has settled.
    @(posedge clk);
    s = tick_cnt[t];
    while (tick_cnt[t] < s + n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) chk("tick wait", 32'h1, 32'h0);
  endtask

  task automatic count_ticks(input int n, input logic [31:0] e);
    int s0l, s1l;
    s0l = tick_cnt[0];
    s1l = tick_cnt[1];
    repeat (n) @(posedge clk);
    chk("ticks t0", e, 32'(tick_cnt[0] - s0l));
    chk("ticks t1", e, 32'(tick_cnt[1] - s1l));
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    bus(1'b0, TPS_GTC_ADDR, 32'h0);
    chk("ctl reset", {24'h0, TPS_GTC_RST}, q);
    bus(1'b0, TPS_CSEL_ADDR, 32'h0);
    chk("csel reset", {24'h0, TPS_CSEL_RST}, q);
    bus(1'b1, TPS_GTC_ADDR, 32'h7E);
    bus(1'b0, TPS_GTC_ADDR, 32'h0);
    chk("ctl reserved", 32'h0, q);
    bus(1'b1, 10'h3FC, 32'hFF);
    bus(1'b0, 10'h3FC, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, TPS_CSEL_ADDR, 32'h53);
    bus(1'b0, TPS_CSEL_ADDR, 32'h0);
    chk("csel fields", 32'h53, q);
  endtask

  task automatic t_none_direct();
    bus(1'b1, TPS_CSEL_ADDR, 32'h00);
    count_ticks(50, 32'd0);
    bus(1'b1, TPS_CSEL_ADDR, 32'h11);
    @(posedge clk);
    count_ticks(20, 32'd20);
  endtask

  task automatic t_taps();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, TPS_CSEL_ADDR, 32'h20 | 32'(i + 2));
      c0 = last;
      wait_ticks(0, 1);
      d = tick_cyc[0] - c0;
      chk("first tick", 32'h1, 32'(d >= 1 && d <= divs[i] + 1));
      wait_ticks(0, 1);
      chk("tap period", 32'(divs[i]), 32'(tick_cyc[0] - tick_prev[0]));
      chk("t1 period", 32'd8, 32'(tick_cyc[1] - tick_prev[1]));
    end
  endtask

  task automatic t_free_run();
    bus(1'b0, TPS_STAT_ADDR, 32'h0);
    s0 = q;
    c0 = last;
    bus(1'b1, TPS_CSEL_ADDR, 32'h54);
    bus(1'b0, TPS_STAT_ADDR, 32'h0);
    chk("free run", 32'(last - c0) & 32'h3FF, (q - s0) & 32'h3FF);
    chk("pin level", 32'h0, q & 32'h30000);
  endtask

  task automatic t_psr();
    bus(1'b1, TPS_CSEL_ADDR, 32'h22);
    bus(1'b1, TPS_GTC_ADDR, 32'h81);
    bus(1'b0, TPS_GTC_ADDR, 32'h0);
    chk("hold ctl", 32'h81, q);
    chk("psr out", 32'h1, {31'h0, psr});
    count_ticks(40, 32'd0);
    bus(1'b1, TPS_GTC_ADDR, 32'h00);
    c0 = last;
    wait_ticks(0, 1);
    chk("same start", 32'(tick_cyc[0]), 32'(tick_cyc[1]));
    d = tick_cyc[0] - c0;
    chk("restart", 32'h1, 32'(d >= 8 && d <= 10));
    bus(1'b0, TPS_GTC_ADDR, 32'h0);
    chk("hold off", 32'h0, q);
    chk("psr out", 32'h0, {31'h0, psr});
    bus(1'b1, TPS_GTC_ADDR, 32'h01);
    c0 = last;
    wait_ticks(0, 1);
    d = tick_cyc[0] - c0;
    chk("psr pulse", 32'h1, 32'(d >= 8 && d <= 10));
    bus(1'b0, TPS_GTC_ADDR, 32'h0);
    chk("self clear", 32'h0, q);
  endtask

  task automatic t_ext(input logic [7:0] h, input logic [7:0] n);
    bus(1'b1, TPS_CSEL_ADDR, 32'h67);
    half   <= h;
    pulses <= n;
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    count_ticks(2 * h * n + 8, 32'(n));
    chk("rise delay", 32'd3, 32'(tick_cyc[0] - rise_cyc));
    chk("fall delay", 32'd3, 32'(tick_cyc[1] - fall_cyc));
  endtask

  // ==========================================================================
  // Main sequence and verdict
  // ==========================================================================
  task automatic end_of_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    rd    = 1'b0;
    wr    = 1'b0;
    go    = 1'b0;
    addr  = 10'h000;
    wdata = 32'h0;
    half  = 8'h03;
    pulses = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_none_direct();
    t_taps();
    t_free_run();
    t_psr();
    t_ext(8'h03, 8'h05);
    t_ext(8'h02, 8'h04);
    end_of_test();
  end
endmodule // tps_top_tb_top
